// ===== rtl/cscc_core.sv
`timescale 1ns/100ps
// Notes on behaviour
// [R1] Bits 15,14 report accumulator overflow, reset 0.
// [R2] Bits 13,12 sticky clip flags, software clears.
// [R3] Bit 11 is OR of overflow flags.
// [R4] Bit 10 ORs clips; clearing clears both.
// [R5] Bits 9,4 show DO and REPEAT activity.
// [R6] Half carry out of bit 3 (byte) or bit 7 (word).
// [R7] Priority is config bit 3 over bits 7-5.
// [R8] User interrupts off at msb or 111.
// [R9] Priority field locked when nesting disabled.
// [R10] Negative flag follows result sign.
// [R11] Wrap flag on signed overflow.
// [R12] Zero flag cleared by nonzero result or by software writing 0.
// [R13] Carry from msb; not-borrow for subtraction.
// [R14] Config bit 12 selects unsigned multiply.
// [R15] Writing 1 to bit 11 ends loop.
// [R16] Bits 10-8 show loop nesting depth.
// [R17] Bits 7,6 enable accumulator clipping.
// [R18] Bit 5 memory write clip, resets 1.
// [R19] Bit 4 selects clip width.
// [R20] Bit 3 readable, clearable, never set by software.
// [R21] Bit 2 enables program window.
// [R22] Bit 1 rounding, bit 0 integer multiply.
module cscc_core (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire cscc_pkg::cscc_alu_t ALU_I,
    input wire cscc_pkg::cscc_acc_t ACC_I,
    input wire cscc_pkg::cscc_loop_t LOOP_I,
    input wire logic PRIO_LOAD_I,
    input wire logic [3:0] PRIO_VALUE_I,
    output logic [3:0] PRIORITY_O,
    output logic USER_INT_DISABLE_O,
    output logic EARLY_EXIT_O,
    output logic [15:0] CONFIG_O
);

    ////////////////////////////////////////////////////////////////////////////
    // Flag arithmetic helpers.

    // Carry out of bit n-1 of a+b (or a-b as a+~b+cin).
    function automatic logic carry_at(input logic [15:0] a, input logic [15:0] b, input logic cin, input int n);
        logic [16:0] s;
        s = 17'h0_0000;
        for (int i = 0; i <= 15; i++) begin
            if (i < n) begin
                s[i] = 1'b1;
            end
        end
        carry_at = ((({1'b0, a} & s) + ({1'b0, b} & s) + {16'h0000, cin}) >> n) != 17'h0_0000;
    endfunction : carry_at

    ////////////////////////////////////////////////////////////////////////////
    // Bus address phase capture.

    logic ph_write;
    logic [11:0] ph_addr;
    logic next_ph_write;
    logic next_ph_read;
    logic [11:0] next_ph_addr;
    logic access;

    always_comb begin
        access = HSEL_I && HREADY_I && HTRANS_I[1];
        next_ph_write = access && HWRITE_I;
        next_ph_read = access && !HWRITE_I;
        next_ph_addr = access ? HADDR_I[11:0] : ph_addr;
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ph_write <= 1'b0;
            ph_addr <= 12'h000;
        end else begin
            ph_write <= next_ph_write;
            ph_addr <= next_ph_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register state.

    logic [15:0] flags;
    logic [15:0] config_r;
    logic nest_dis;
    logic [15:0] next_flags;
    logic [15:0] next_config;
    logic next_nest_dis;
    logic next_exit;
    logic wr_flags;
    logic wr_config;
    logic [15:0] wd;
    logic [16:0] sum;
    logic [15:0] res;
    logic [15:0] bop;
    logic cin;
    logic neg;
    logic [3:0] prio;

    always_comb begin
        wd = HWDATA_I[15:0];
        wr_flags = ph_write && (ph_addr == cscc_pkg::FLAGS_ADDR);
        wr_config = ph_write && (ph_addr == cscc_pkg::CONFIG_ADDR);
        next_flags = flags;
        next_config = config_r;
        next_nest_dis = nest_dis;
        next_exit = 1'b0;

        // Software writes first; hardware events below override them.
        if (wr_flags) begin
            if (!wd[cscc_pkg::FL_CLIP_A]) begin
                next_flags[cscc_pkg::FL_CLIP_A] = 1'b0; // [R2]
            end
            if (!wd[cscc_pkg::FL_CLIP_B]) begin
                next_flags[cscc_pkg::FL_CLIP_B] = 1'b0; // [R2]
            end
            if (!wd[cscc_pkg::FL_CLIP_ANY]) begin
                next_flags[cscc_pkg::FL_CLIP_A] = 1'b0; // [R4]
                next_flags[cscc_pkg::FL_CLIP_B] = 1'b0; // [R4]
            end
            if (!nest_dis) begin
                next_flags[cscc_pkg::FL_PRIO_LO +: 3] = wd[cscc_pkg::FL_PRIO_LO +: 3]; // [R9]
            end
            next_flags[cscc_pkg::FL_HALF] = wd[cscc_pkg::FL_HALF];
            next_flags[cscc_pkg::FL_NEG] = wd[cscc_pkg::FL_NEG];
            next_flags[cscc_pkg::FL_WRAP] = wd[cscc_pkg::FL_WRAP];
            next_flags[cscc_pkg::FL_ZERO] = wd[cscc_pkg::FL_ZERO];
            next_flags[cscc_pkg::FL_CARRY] = wd[cscc_pkg::FL_CARRY];
        end
        if (wr_config) begin
            next_config[cscc_pkg::CF_UNSIGNED] = wd[cscc_pkg::CF_UNSIGNED]; // [R14]
            next_exit = wd[cscc_pkg::CF_EXIT]; // [R15]
            next_config[cscc_pkg::CF_CLIP_A_EN] = wd[cscc_pkg::CF_CLIP_A_EN]; // [R17]
            next_config[cscc_pkg::CF_CLIP_B_EN] = wd[cscc_pkg::CF_CLIP_B_EN]; // [R17]
            next_config[cscc_pkg::CF_MEM_CLIP] = wd[cscc_pkg::CF_MEM_CLIP]; // [R18]
            next_config[cscc_pkg::CF_WIDTH] = wd[cscc_pkg::CF_WIDTH]; // [R19]
            if (!wd[cscc_pkg::CF_PRIO_MSB]) begin
                next_config[cscc_pkg::CF_PRIO_MSB] = 1'b0; // [R20]
            end
            next_config[cscc_pkg::CF_WINDOW] = wd[cscc_pkg::CF_WINDOW]; // [R21]
            next_config[cscc_pkg::CF_ROUND] = wd[cscc_pkg::CF_ROUND]; // [R22]
            next_config[cscc_pkg::CF_INTEGER] = wd[cscc_pkg::CF_INTEGER]; // [R22]
        end
        if (ph_write && (ph_addr == cscc_pkg::INTCTL_ADDR)) begin
            next_nest_dis = wd[cscc_pkg::IC_NEST_DIS];
        end

        // Pipeline priority load outranks software and the lock.
        if (PRIO_LOAD_I) begin
            next_flags[cscc_pkg::FL_PRIO_LO +: 3] = PRIO_VALUE_I[2:0];
            next_config[cscc_pkg::CF_PRIO_MSB] = PRIO_VALUE_I[3];
        end

        // Accumulator status: overflow follows the latest pass, clip is sticky.
        if (ACC_I.valid_a) begin
            next_flags[cscc_pkg::FL_OVF_A] = ACC_I.ovf_a; // [R1]
        end
        if (ACC_I.valid_b) begin
            next_flags[cscc_pkg::FL_OVF_B] = ACC_I.ovf_b; // [R1]
        end
        if (ACC_I.valid_a && ACC_I.sat_a) begin
            next_flags[cscc_pkg::FL_CLIP_A] = 1'b1; // [R2]
        end
        if (ACC_I.valid_b && ACC_I.sat_b) begin
            next_flags[cscc_pkg::FL_CLIP_B] = 1'b1; // [R2]
        end

        // ALU result flags; subtraction is a + ~b + cin, so carry reads as not-borrow.
        bop = ALU_I.subtract ? ~ALU_I.b : ALU_I.b; // [R13]
        cin = ALU_I.carry_in;
        sum = {1'b0, ALU_I.a} + {1'b0, bop} + {16'h0000, cin};
        res = sum[15:0];
        if (ALU_I.valid) begin
            if (ALU_I.byte_op) begin
                neg = res[7];
                next_flags[cscc_pkg::FL_HALF] = carry_at(ALU_I.a, bop, cin, 4); // [R6]
                next_flags[cscc_pkg::FL_CARRY] = carry_at(ALU_I.a, bop, cin, 8); // [R13]
                next_flags[cscc_pkg::FL_WRAP] = (ALU_I.a[7] == bop[7]) && (res[7] != ALU_I.a[7]); // [R11]
                if (res[7:0] != 8'h00) begin
                    next_flags[cscc_pkg::FL_ZERO] = 1'b0; // [R12]
                end
            end else begin
                neg = res[15];
                next_flags[cscc_pkg::FL_HALF] = carry_at(ALU_I.a, bop, cin, 8); // [R6]
                next_flags[cscc_pkg::FL_CARRY] = sum[16]; // [R13]
                next_flags[cscc_pkg::FL_WRAP] = (ALU_I.a[15] == bop[15]) && (res[15] != ALU_I.a[15]); // [R11]
                if (res != 16'h0000) begin
                    next_flags[cscc_pkg::FL_ZERO] = 1'b0; // [R12]
                end
            end
            next_flags[cscc_pkg::FL_NEG] = neg; // [R10]
        end else begin
            neg = 1'b0;
        end

        // Derived and mirrored fields.
        next_flags[cscc_pkg::FL_OVF_ANY] = next_flags[cscc_pkg::FL_OVF_A] | next_flags[cscc_pkg::FL_OVF_B]; // [R3]
        next_flags[cscc_pkg::FL_CLIP_ANY] = next_flags[cscc_pkg::FL_CLIP_A] | next_flags[cscc_pkg::FL_CLIP_B]; // [R4]
        next_flags[cscc_pkg::FL_DO_ACT] = LOOP_I.do_active; // [R5]
        next_flags[cscc_pkg::FL_REP_ACT] = LOOP_I.rep_active; // [R5]
        next_config[cscc_pkg::CF_DEPTH_LO +: 3] = LOOP_I.depth; // [R16]
        next_config[cscc_pkg::CF_EXIT] = 1'b0; // [R15]
        next_config[15:13] = 3'h0;

        prio = {next_config[cscc_pkg::CF_PRIO_MSB], next_flags[cscc_pkg::FL_PRIO_LO +: 3]}; // [R7]
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            flags <= cscc_pkg::FLAGS_RESET;
            config_r <= cscc_pkg::CONFIG_RESET; // [R18]
            nest_dis <= 1'b0;
        end else begin
            flags <= next_flags;
            config_r <= next_config;
            nest_dis <= next_nest_dis;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all registered. The priority outputs follow the registers with no extra lag.

    logic [31:0] next_rdata;
    logic next_user_dis;

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (next_ph_read) begin
            case (HADDR_I[11:0])
                cscc_pkg::FLAGS_ADDR: next_rdata = {16'h0000, next_flags};
                cscc_pkg::CONFIG_ADDR: next_rdata = {16'h0000, next_config};
                cscc_pkg::INTCTL_ADDR: next_rdata = {16'h0000, next_nest_dis, 15'h0000};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        next_user_dis = prio[3] || (prio[2:0] == cscc_pkg::PRIO_ALL_MASKED); // [R8]
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            HRDATA_O <= 32'h0000_0000;
            PRIORITY_O <= 4'h0;
            USER_INT_DISABLE_O <= 1'b0;
            EARLY_EXIT_O <= 1'b0;
            CONFIG_O <= cscc_pkg::CONFIG_RESET;
        end else begin
            HRDATA_O <= next_rdata;
            PRIORITY_O <= prio; // [R7]
            USER_INT_DISABLE_O <= next_user_dis; // [R8]
            EARLY_EXIT_O <= next_exit; // [R15]
            CONFIG_O <= next_config; // [R21]
        end
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end else begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end
    end

endmodule : cscc_core

// ===== rtl/cscc_pkg.sv
package cscc_pkg;

    // Register byte addresses on the bus.
    localparam logic [11:0] FLAGS_ADDR = 12'h000;
    localparam logic [11:0] CONFIG_ADDR = 12'h004;
    localparam logic [11:0] INTCTL_ADDR = 12'h008;

    // Flag register bit positions.
    localparam int FL_OVF_A = 15;
    localparam int FL_OVF_B = 14;
    localparam int FL_CLIP_A = 13;
    localparam int FL_CLIP_B = 12;
    localparam int FL_OVF_ANY = 11;
    localparam int FL_CLIP_ANY = 10;
    localparam int FL_DO_ACT = 9;
    localparam int FL_HALF = 8;
    localparam int FL_PRIO_LO = 5;
    localparam int FL_REP_ACT = 4;
    localparam int FL_NEG = 3;
    localparam int FL_WRAP = 2;
    localparam int FL_ZERO = 1;
    localparam int FL_CARRY = 0;

    // Core configuration bit positions.
    localparam int CF_UNSIGNED = 12;
    localparam int CF_EXIT = 11;
    localparam int CF_DEPTH_LO = 8;
    localparam int CF_CLIP_A_EN = 7;
    localparam int CF_CLIP_B_EN = 6;
    localparam int CF_MEM_CLIP = 5;
    localparam int CF_WIDTH = 4;
    localparam int CF_PRIO_MSB = 3;
    localparam int CF_WINDOW = 2;
    localparam int CF_ROUND = 1;
    localparam int CF_INTEGER = 0;

    // Interrupt control bit position.
    localparam int IC_NEST_DIS = 15;

    // Reset values and the all-masked priority level.
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] CONFIG_RESET = 16'h0020;
    localparam logic [2:0] PRIO_ALL_MASKED = 3'h7;

    // Operands of one ALU operation offered by the pipeline.
    typedef struct packed {
        logic valid;
        logic byte_op;
        logic subtract;
        logic [15:0] a;
        logic [15:0] b;
        logic carry_in;
    } cscc_alu_t;

    // Accumulator status offered by the DSP engine.
    typedef struct packed {
        logic valid_a;
        logic ovf_a;
        logic sat_a;
        logic valid_b;
        logic ovf_b;
        logic sat_b;
    } cscc_acc_t;

    // Loop tracking from the sequencer.
    typedef struct packed {
        logic do_active;
        logic rep_active;
        logic [2:0] depth;
    } cscc_loop_t;

endpackage : cscc_pkg

// ===== testbench/cscc_sva.sv
`timescale 1ns/100ps
module cscc_sva (
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic [31:0] HRDATA_O,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    input wire cscc_pkg::cscc_loop_t LOOP_I,
    input wire logic PRIO_LOAD_I,
    input wire logic [3:0] PRIO_VALUE_I,
    input wire logic [3:0] PRIORITY_O,
    input wire logic USER_INT_DISABLE_O,
    input wire logic EARLY_EXIT_O,
    input wire logic [15:0] CONFIG_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    a_prio_load: assert property (PRIO_LOAD_I |=> PRIORITY_O == $past(PRIO_VALUE_I))
        else $error("priority load lost");
    a_udis_rule: assert property (USER_INT_DISABLE_O == (PRIORITY_O[3] || PRIORITY_O[2:0] == 3'h7))
        else $error("user interrupt disable wrong");
    a_msb_source: assert property ($rose(PRIORITY_O[3]) |-> $past(PRIO_LOAD_I) && $past(PRIO_VALUE_I[3]))
        else $error("priority msb set by software");
    a_exit_pulse: assert property (EARLY_EXIT_O |=> !EARLY_EXIT_O)
        else $error("loop exit not a pulse");
    a_exit_reads0: assert property (CONFIG_O[15:13] == 3'h0 && !CONFIG_O[11])
        else $error("config reserved or exit bit set");
    // The depth must settle while the sequencer holds it; up to three register stages are tolerated.
    a_loop_depth: assert property ($stable(LOOP_I.depth) [*3] |-> CONFIG_O[10:8] == LOOP_I.depth)
        else $error("loop depth not mirrored");
    a_bus_okay: assert property (HREADYOUT_O && !HRESP_O)
        else $error("bus not ready or not okay");
    a_rdata_upper: assert property (HRDATA_O[31:16] == 16'h0000)
        else $error("read data upper half set");
endmodule : cscc_sva

// ===== testbench/cscc_core_tb.sv
`timescale 1ns/100ps
module cscc_core_tb;
    logic CLK_I, RESET_N_I, HSEL_I, HWRITE_I, HREADY_I, PRIO_LOAD_I;
    logic [31:0] HADDR_I, HWDATA_I, HRDATA_O;
    logic [1:0] HTRANS_I;
    logic [2:0] HSIZE_I;
    logic [3:0] PRIO_VALUE_I, PRIORITY_O;
    logic HREADYOUT_O, HRESP_O, USER_INT_DISABLE_O, EARLY_EXIT_O;
    logic [15:0] CONFIG_O, rd, exp_f;
    cscc_pkg::cscc_alu_t ALU_I, op;
    cscc_pkg::cscc_acc_t ACC_I;
    cscc_pkg::cscc_loop_t LOOP_I;
    int error_cnt, comparisons, cycles, exits;
    logic [31:0] lfsr = 32'h4163_9840;
    assign HREADY_I = HREADYOUT_O;
    cscc_core dut (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
        .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
        .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
        .ALU_I(ALU_I), .ACC_I(ACC_I), .LOOP_I(LOOP_I), .PRIO_LOAD_I(PRIO_LOAD_I),
        .PRIO_VALUE_I(PRIO_VALUE_I), .PRIORITY_O(PRIORITY_O), .USER_INT_DISABLE_O(USER_INT_DISABLE_O),
        .EARLY_EXIT_O(EARLY_EXIT_O), .CONFIG_O(CONFIG_O));
    initial begin
        CLK_I = 1'b0;
        forever #2 CLK_I = ~CLK_I;
    end
    always @(posedge CLK_I) begin
        cycles++;
        if (EARLY_EXIT_O === 1'b1) exits++;
        if (cycles == 5000) begin
            error_cnt++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    // Zero is cleared by a nonzero result or a software write of 0; a zero result leaves it as it was.
    function automatic logic [15:0] alu_exp(input cscc_pkg::cscc_alu_t o, input logic [15:0] f);
        logic [15:0] b;
        logic [16:0] s;
        logic [8:0] bsum;
        logic [4:0] h;
        b = o.subtract ? ~o.b : o.b;
        s = 17'(o.a) + 17'(b) + 17'(o.carry_in);
        bsum = 9'(o.a[7:0]) + 9'(b[7:0]) + 9'(o.carry_in);
        h = 5'(o.a[3:0]) + 5'(b[3:0]) + 5'(o.carry_in);
        f[8] = o.byte_op ? h[4] : bsum[8];
        f[0] = o.byte_op ? bsum[8] : s[16];
        f[3] = o.byte_op ? bsum[7] : s[15];
        f[2] = o.byte_op ? (o.a[7] == b[7] && bsum[7] != o.a[7]) : (o.a[15] == b[15] && s[15] != o.a[15]);
        if ((o.byte_op ? bsum[7:0] : s[7:0] | s[15:8]) != 8'h00) f[1] = 1'b0;
        return f;
    endfunction : alu_exp
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d);
        @(posedge CLK_I);
        HSEL_I <= 1'b1;
        HTRANS_I <= 2'h2;
        HWRITE_I <= w;
        HADDR_I <= {20'h0_0000, a};
        do @(posedge CLK_I); while (HREADY_I !== 1'b1);
        HSEL_I <= 1'b0;
        HTRANS_I <= 2'h0;
        HWDATA_I <= {16'h0000, d};
        do @(posedge CLK_I); while (HREADY_I !== 1'b1);
        rd = HRDATA_O[15:0];
    endtask : bus
    task automatic acc(input logic [5:0] v);
        @(posedge CLK_I);
        ACC_I <= cscc_pkg::cscc_acc_t'(v);
        @(posedge CLK_I);
        ACC_I <= '0;
    endtask : acc
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {RESET_N_I, HSEL_I, HADDR_I, HTRANS_I, HWRITE_I, HWDATA_I, PRIO_LOAD_I, PRIO_VALUE_I} = '0;
        HSIZE_I = 3'h2;
        ALU_I = '0;
        ACC_I = '0;
        LOOP_I = '0;
        repeat (10) @(posedge CLK_I);
        RESET_N_I <= 1'b1;
        bus(1'b0, cscc_pkg::FLAGS_ADDR, 16'h0000);
        chk("flags", 16'h0000, rd);
        bus(1'b0, cscc_pkg::CONFIG_ADDR, 16'h0000);
        chk("config", 16'h0020, rd);
        chk("config_o", 16'h0020, CONFIG_O);
        bus(1'b0, 12'h00C, 16'h0000);
        chk("unmapped", 16'h0000, rd);
        bus(1'b1, cscc_pkg::CONFIG_ADDR, 16'hFFFF);
        bus(1'b0, cscc_pkg::CONFIG_ADDR, 16'h0000);
        chk("config", 16'h10F7, rd);
        bus(1'b1, cscc_pkg::CONFIG_ADDR, 16'h0000);
        bus(1'b0, cscc_pkg::CONFIG_ADDR, 16'h0000);
        chk("config", 16'h0000, rd);
        chk("exits", 16'h0001, 16'(exits));
        LOOP_I <= '{1'b1, 1'b0, 3'h5};
        bus(1'b0, cscc_pkg::FLAGS_ADDR, 16'h0000);
        chk("loops", 16'h0200, rd & 16'h0210);
        bus(1'b0, cscc_pkg::CONFIG_ADDR, 16'h0000);
        chk("depth", 16'h0500, rd);
        LOOP_I <= '{1'b0, 1'b1, 3'h7};
        bus(1'b0, cscc_pkg::FLAGS_ADDR, 16'h0000);
        chk("loops", 16'h0010, rd & 16'h0210);
        bus(1'b0, cscc_pkg::CONFIG_ADDR, 16'h0000);
        chk("depth", 16'h0700, rd);
        LOOP_I <= '0;
        @(posedge CLK_I);
        PRIO_LOAD_I <= 1'b1;
        PRIO_VALUE_I <= 4'hA;
        @(posedge CLK_I);
        PRIO_LOAD_I <= 1'b0;
        bus(1'b0, cscc_pkg::CONFIG_ADDR, 16'h0000);
        chk("msb", 16'h0008, rd & 16'h0008);
        chk("prio", 16'h000A, 16'(PRIORITY_O));
        chk("udis", 16'h0001, 16'(USER_INT_DISABLE_O));
        bus(1'b1, cscc_pkg::CONFIG_ADDR, 16'h0000);
        bus(1'b1, cscc_pkg::FLAGS_ADDR, 16'h00E0);
        bus(1'b0, cscc_pkg::FLAGS_ADDR, 16'h0000);
        chk("prio", 16'h0007, 16'(PRIORITY_O));
        chk("udis", 16'h0001, 16'(USER_INT_DISABLE_O));
        bus(1'b1, cscc_pkg::INTCTL_ADDR, 16'h8000);
        bus(1'b1, cscc_pkg::FLAGS_ADDR, 16'h0000);
        bus(1'b0, cscc_pkg::FLAGS_ADDR, 16'h0000);
        chk("locked", 16'h00E0, rd & 16'h00E0);
        bus(1'b1, cscc_pkg::INTCTL_ADDR, 16'h0000);
        bus(1'b1, cscc_pkg::FLAGS_ADDR, 16'h0000);
        // The write lands at the edge the task returns on, and the registered output updates at that same edge; the check still waits one edge more.
        @(posedge CLK_I);
        chk("udis", 16'h0000, 16'(USER_INT_DISABLE_O));
        acc(6'h38);
        bus(1'b0, cscc_pkg::FLAGS_ADDR, 16'h0000);
        chk("acc", 16'hAC00, rd & 16'hFC00);
        acc(6'h20);
        bus(1'b0, cscc_pkg::FLAGS_ADDR, 16'h0000);
        chk("acc", 16'h2400, rd & 16'hFC00);
        acc(6'h07);
        bus(1'b0, cscc_pkg::FLAGS_ADDR, 16'h0000);
        chk("acc", 16'h7C00, rd & 16'hFC00);
        bus(1'b1, cscc_pkg::FLAGS_ADDR, 16'h3000);
        bus(1'b0, cscc_pkg::FLAGS_ADDR, 16'h0000);
        chk("acc", 16'h4800, rd & 16'hFC00);
        acc(6'h28);
        bus(1'b1, cscc_pkg::FLAGS_ADDR, 16'h0400);
        bus(1'b1, cscc_pkg::FLAGS_ADDR, 16'h3C00);
        bus(1'b0, cscc_pkg::FLAGS_ADDR, 16'h0000);
        chk("acc", 16'h4800, rd & 16'hFC00);
        exp_f = 16'h0002;
        bus(1'b1, cscc_pkg::FLAGS_ADDR, exp_f);
        for (int i = 0; i < 24; i++) begin
            lfsr = nxt(lfsr);
            op = {1'b1, lfsr[1:0], lfsr[31:16], lfsr[15:0], lfsr[2]};
            if (i < 2) op.b = op.a;
            if (i < 2) op.subtract = 1'b1;
            if (i < 2) op.carry_in = 1'b1;
            if (i == 2) op = '{1'b1, 1'b0, 1'b0, 16'h7FFF, 16'h0001, 1'b0};
            @(posedge CLK_I);
            ALU_I <= op;
            @(posedge CLK_I);
            ALU_I <= '0;
            exp_f = alu_exp(op, exp_f);
            bus(1'b0, cscc_pkg::FLAGS_ADDR, 16'h0000);
            chk("alu", exp_f & 16'h010F, rd & 16'h010F);
        end
        wrap_up();
    end
endmodule : cscc_core_tb
bind cscc_core cscc_sva u_sva (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .HRDATA_O(HRDATA_O),
    .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .LOOP_I(LOOP_I), .PRIO_LOAD_I(PRIO_LOAD_I),
    .PRIO_VALUE_I(PRIO_VALUE_I), .PRIORITY_O(PRIORITY_O), .USER_INT_DISABLE_O(USER_INT_DISABLE_O),
    .EARLY_EXIT_O(EARLY_EXIT_O), .CONFIG_O(CONFIG_O));
